/* File: verilog/tlbps_map.svh */
// constants for the translation buffer maintenance block
`ifndef TLBPS_MAP_SVH
`define TLBPS_MAP_SVH
`define TLBPS_ENTRIES      8
`define TLBPS_IDX_W        3
`define TLBPS_EPN_W        20
`define TLBPS_RPN_W        20
`define TLBPS_ATTR_W       7
`define TLBPS_R_BYTE_MASK  8'hFE
`define TLBPS_R_BIT_W64    48
`define TLBPS_R_BIT_W32    16
`define TLBPS_SYNC_TIMEOUT_NS 200000
`define TLBPS_SYNC_TIMEOUT_CYC ((`TLBPS_SYNC_TIMEOUT_NS) / 20)
`endif

/* File: verilog/tlbps_pkg.sv */
// types for the translation buffer maintenance block
package tlbps_pkg;
   typedef enum logic [1:0] {
      TLBPS_OP_NONE,
      TLBPS_OP_INVAL,
      TLBPS_OP_SYNC,
      TLBPS_OP_FULL
   } tlbps_op_t;
   typedef enum {
      TLBPS_IDLE,
      TLBPS_BCAST,
      TLBPS_WAIT,
      TLBPS_DONE
   } tlbps_state_t;
endpackage

/* File: verilog/tlbps_entry.sv */
// one translation buffer entry with match and remove logic
`timescale 1ns/1ns
`include "tlbps_map.svh"
module tlbps_entry (
   input  wire logic                       clk_i,
   input  wire logic                       rst_n_i,
   input  wire logic                       ce_i,
   input  wire logic                       fill_i,
   input  wire logic                       kill_i,
   input  wire logic [`TLBPS_EPN_W-1:0]    fill_epn_i,
   input  wire logic [`TLBPS_RPN_W-1:0]    fill_rpn_i,
   input  wire logic [`TLBPS_ATTR_W-1:0]   fill_attr_i,
   input  wire logic [`TLBPS_EPN_W-1:0]    look_epn_i,
   input  wire logic [`TLBPS_EPN_W-1:0]    kill_epn_i,
   output logic                            hit_o,
   output logic                            valid_o,
   output logic [`TLBPS_RPN_W-1:0]         rpn_o,
   output logic [`TLBPS_ATTR_W-1:0]        attr_o
);
   logic                      valid;
   logic [`TLBPS_EPN_W-1:0]   epn;
   wire                       kill_match = kill_i && valid && (epn == kill_epn_i);

   // entry holds only what was loaded; memory edits never touch it
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         valid  <= 1'b0;
         epn    <= '0;
         rpn_o  <= '0;
         attr_o <= '0;
      end else if (ce_i) begin
         if (fill_i) begin
            valid  <= 1'b1;
            epn    <= fill_epn_i;
            rpn_o  <= fill_rpn_i;
            attr_o <= fill_attr_i;
         end else if (kill_match) begin
            valid <= 1'b0;
         end
      end
   end

   assign hit_o   = valid && (epn == look_epn_i);
   assign valid_o = valid;
endmodule

/* File: verilog/tlbps_top.sv */
// translation buffer with invalidate, invalidation-sync and reference/change updates
`timescale 1ns/1ns
`include "tlbps_map.svh"
module tlbps_top
   import tlbps_pkg::*;
#(
   parameter int SYNC_TIMEOUT_CYC = `TLBPS_SYNC_TIMEOUT_CYC
) (
   input  wire logic                       clk_i,
   input  wire logic                       rst_n_i,
   input  wire logic                       ce_i,
   input  wire logic                       wide_mode_bit_i,
   input  wire tlbps_pkg::tlbps_op_t       op_i,
   input  wire logic                       op_valid_i,
   input  wire logic [`TLBPS_EPN_W-1:0]    op_epn_i,
   output logic                            op_ready_o,
   output logic                            op_done_o,
   output logic                            sync_timeout_o,
   input  wire logic [`TLBPS_EPN_W-1:0]    look_epn_i,
   input  wire logic                       look_store_i,
   output logic                            look_hit_o,
   output logic [`TLBPS_RPN_W-1:0]         look_rpn_o,
   output logic [`TLBPS_ATTR_W-1:0]        look_attr_o,
   input  wire logic                       reload_valid_i,
   input  wire logic [`TLBPS_EPN_W-1:0]    reload_epn_i,
   input  wire logic [`TLBPS_RPN_W-1:0]    reload_rpn_i,
   input  wire logic [`TLBPS_ATTR_W-1:0]   reload_attr_i,
   output logic                            rc_wr_o,
   output logic                            rc_changed_o,
   output logic [`TLBPS_EPN_W-1:0]         rc_epn_o,
   output logic [7:0]                      rc_byte_mask_o,
   output logic [5:0]                      rc_bit_pos_o,
   output logic                            bcast_inval_o,
   output logic [`TLBPS_EPN_W-1:0]         bcast_epn_o,
   input  wire logic                       peer_ack_i
);
   localparam int N = `TLBPS_ENTRIES;

   tlbps_state_t             state;
   tlbps_state_t             next_state;
   logic [N-1:0]             hit_vec;
   logic [N-1:0]             valid_vec;
   logic [`TLBPS_RPN_W-1:0]  rpn_arr  [N];
   logic [`TLBPS_ATTR_W-1:0] attr_arr [N];
   logic [`TLBPS_IDX_W-1:0]  victim;
   logic                     pend_inval;
   logic                     ack_s1;
   logic                     ack_s2;
   logic                     ack_s3;
   logic                     ack_low_seen;
   logic [31:0]              wait_cnt;

   // first-set index of a vector, used for hit select and free slot
   function automatic logic [`TLBPS_IDX_W-1:0] first_one(input logic [N-1:0] v);
      logic [`TLBPS_IDX_W-1:0] r;
      r = '0;
      for (int k = N - 1; k >= 0; k--) begin
         if (v[k]) begin
            r = k[`TLBPS_IDX_W-1:0];
         end
      end
      return r;
   endfunction

   wire                      any_free  = ~&valid_vec;
   wire [`TLBPS_IDX_W-1:0]   free_idx  = first_one(~valid_vec);
   wire [`TLBPS_IDX_W-1:0]   fill_idx  = any_free ? free_idx : victim;
   wire [`TLBPS_IDX_W-1:0]   hit_idx   = first_one(hit_vec);
   wire                      any_hit   = |hit_vec;
   wire                      accept    = op_valid_i && op_ready_o;
   wire                      do_inval  = accept && (op_i == TLBPS_OP_INVAL);
   wire                      ack_seen  = ack_s2 && ack_s3;
   wire                      ack_clear = !ack_s2 && !ack_s3;
   // a store hit wins a shared update cycle: a lost referenced mark is harmless, a lost changed mark is not
   wire                      store_hit = any_hit && look_store_i;

   // entries; reload may arrive any cycle, even mid-edit
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_ent
         tlbps_entry u_ent (
            .clk_i       (clk_i),
            .rst_n_i     (rst_n_i),
            .ce_i        (ce_i),
            .fill_i      (reload_valid_i && (fill_idx == g)),
            .kill_i      (do_inval),
            .fill_epn_i  (reload_epn_i),
            .fill_rpn_i  (reload_rpn_i),
            .fill_attr_i (reload_attr_i),
            .look_epn_i  (look_epn_i),
            .kill_epn_i  (op_epn_i),
            .hit_o       (hit_vec[g]),
            .valid_o     (valid_vec[g]),
            .rpn_o       (rpn_arr[g]),
            .attr_o      (attr_arr[g])
         );
      end
   endgenerate

   // lookup result; no snoop path exists, so stale hits are software's problem
   assign look_hit_o  = any_hit;
   assign look_rpn_o  = rpn_arr[hit_idx];
   assign look_attr_o = attr_arr[hit_idx];

   // round-robin victim when full
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         victim <= '0;
      end else if (ce_i && reload_valid_i && !any_free) begin
         victim <= victim + 1'b1;
      end
   end

   // peer acknowledge arrives from another processor: three-stage sync
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
         ack_s3 <= 1'b0;
      end else if (ce_i) begin
         ack_s1 <= peer_ack_i;
         ack_s2 <= ack_s1;
         ack_s3 <= ack_s2;
      end
   end

   // remember that an invalidate went out since the last sync or full op reached done
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pend_inval <= 1'b0;
      end else if (ce_i) begin
         if (do_inval) begin
            pend_inval <= 1'b1;
         end else if (state == TLBPS_DONE) begin
            pend_inval <= 1'b0;
         end
      end
   end

   // a high ack only counts after it was seen low inside the wait;
   // a level left over from an earlier invalidate would end the wait too early
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         ack_low_seen <= 1'b0;
      end else if (ce_i) begin
         if (state != TLBPS_WAIT) begin
            ack_low_seen <= 1'b0;
         end else if (ack_clear) begin
            ack_low_seen <= 1'b1;
         end
      end
   end

   // sync sequencer
   always_comb begin
      next_state = state;
      unique case (state)
         TLBPS_IDLE: begin
            if (accept && (op_i == TLBPS_OP_SYNC)) begin
               next_state = pend_inval ? TLBPS_BCAST : TLBPS_DONE;
            end else if (accept && (op_i == TLBPS_OP_FULL)) begin
               next_state = TLBPS_DONE;
            end
         end
         TLBPS_BCAST: begin
            next_state = TLBPS_WAIT;
         end
         TLBPS_WAIT: begin
            // timeout only flags; completion still needs the acknowledge
            if (ack_low_seen && ack_seen) begin
               next_state = TLBPS_DONE;
            end
         end
         TLBPS_DONE: begin
            next_state = TLBPS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         state <= TLBPS_IDLE;
      end else if (ce_i) begin
         state <= next_state;
      end
   end

   // wait counter for a stuck peer
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wait_cnt       <= '0;
         sync_timeout_o <= 1'b0;
      end else if (ce_i) begin
         wait_cnt       <= (state == TLBPS_WAIT) ? wait_cnt + 32'h1 : 32'h0;
         sync_timeout_o <= (state == TLBPS_WAIT) && (wait_cnt >= 32'(SYNC_TIMEOUT_CYC));
      end
   end

   assign op_ready_o = (state == TLBPS_IDLE) && ce_i;
   assign op_done_o  = (state == TLBPS_DONE) && ce_i;

   // broadcast of invalidates and of the sync request to peers
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         bcast_inval_o <= 1'b0;
         bcast_epn_o   <= '0;
      end else if (ce_i) begin
         bcast_inval_o <= do_inval || (state == TLBPS_BCAST);
         bcast_epn_o   <= do_inval ? op_epn_i : bcast_epn_o;
      end
   end

   // referenced/changed write-back, posted without waiting on the access
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rc_wr_o        <= 1'b0;
         rc_changed_o   <= 1'b0;
         rc_epn_o       <= '0;
         rc_byte_mask_o <= 8'h00;
         rc_bit_pos_o   <= 6'h00;
      end else if (ce_i) begin
         rc_wr_o        <= reload_valid_i || (any_hit && look_store_i);
         rc_changed_o   <= store_hit;
         rc_epn_o       <= store_hit ? look_epn_i : reload_epn_i;
         rc_byte_mask_o <= ~`TLBPS_R_BYTE_MASK;
         // a mode flip under a running access is unsupported; the position just follows the level
         rc_bit_pos_o   <= wide_mode_bit_i ? 6'(`TLBPS_R_BIT_W64) : 6'(`TLBPS_R_BIT_W32);
      end
   end
endmodule

/* File: verification/tlbps_peer.sv */
// peer processors that acknowledge broadcast invalidates
`timescale 1ns/1ns
module tlbps_peer #(parameter int DELAY = 4) (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic bcast_i,
   input  wire logic mute_i,
   output logic      ack_o
);
   int cnt;
   // each broadcast drops the ack and restarts the count
   always @(posedge clk_i) begin
      if (!rst_n_i || bcast_i) cnt <= 0;
      else if (cnt < DELAY) cnt <= cnt + 1;
   end
   // a muted peer never answers, to force the wait
   assign ack_o = !mute_i && cnt >= DELAY;
endmodule

/* File: verification/tlbps_chk.sv */
// assertions on the translation buffer top ports
`timescale 1ns/1ns
`include "tlbps_map.svh"
module tlbps_chk
   import tlbps_pkg::*;
(
   input  wire logic                       clk_i,
   input  wire logic                       rst_n_i,
   input  wire logic                       ce_i,
   input  wire logic                       wide_mode_bit_i,
   input  wire logic                       op_valid_i,
   input  wire logic                       op_ready_o,
   input  wire logic                       op_done_o,
   input  wire logic                       look_store_i,
   input  wire logic                       look_hit_o,
   input  wire logic                       reload_valid_i,
   input  wire logic                       rc_wr_o,
   input  wire logic                       rc_changed_o,
   input  wire logic                       bcast_inval_o,
   input  wire logic                       peer_ack_i,
   input  wire tlbps_pkg::tlbps_op_t       op_i,
   input  wire logic [`TLBPS_EPN_W-1:0]    op_epn_i,
   input  wire logic [`TLBPS_EPN_W-1:0]    look_epn_i,
   input  wire logic [`TLBPS_EPN_W-1:0]    reload_epn_i,
   input  wire logic [`TLBPS_EPN_W-1:0]    rc_epn_o,
   input  wire logic [`TLBPS_EPN_W-1:0]    bcast_epn_o,
   input  wire logic [7:0]                 rc_byte_mask_o,
   input  wire logic [5:0]                 rc_bit_pos_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   logic owed;
   wire  take = op_valid_i && op_ready_o;
   // a broadcast stays owed until some peer ack is seen
   always_ff @(posedge clk_i) owed <= rst_n_i && (bcast_inval_o || (owed && !peer_ack_i));
   sequence s_inval;
      take && op_i == TLBPS_OP_INVAL && !reload_valid_i;
   endsequence
   inval_bcast_a: assert property (s_inval |=> bcast_inval_o && bcast_epn_o == $past(op_epn_i))
      else $error("no broadcast after invalidate");
   inval_drop_a: assert property (s_inval ##0 look_epn_i == op_epn_i ##1 $stable(look_epn_i) |-> !look_hit_o)
      else $error("entry survives invalidate");
   sync_ack_a: assert property (op_done_o |-> !owed)
      else $error("sync done before peers answered");
   done_pulse_a: assert property (op_done_o && ce_i |=> !op_done_o)
      else $error("done longer than one cycle");
   busy_refuse_a: assert property (take && op_i == TLBPS_OP_SYNC |=> !op_ready_o)
      else $error("ready during sync");
   reload_ref_a: assert property (reload_valid_i && ce_i && !look_store_i |=> rc_wr_o && !rc_changed_o
      && rc_epn_o == $past(reload_epn_i)) else $error("no referenced update");
   store_chg_a: assert property (look_hit_o && look_store_i && ce_i && !reload_valid_i
      |=> rc_wr_o && rc_changed_o) else $error("no changed update");
   rc_only_a: assert property (rc_wr_o && $past(ce_i) |-> $past(reload_valid_i || look_store_i && look_hit_o))
      else $error("stray table write");
   rc_byte_a: assert property (rc_wr_o && $past(ce_i) |-> rc_byte_mask_o == ~`TLBPS_R_BYTE_MASK
      && rc_bit_pos_o == ($past(wide_mode_bit_i) ? 6'h30 : 6'h10)) else $error("bad referenced byte");
   hit_keep_a: assert property (look_hit_o && !op_valid_i && !reload_valid_i ##1 $stable(look_epn_i) |-> look_hit_o)
      else $error("entry dropped on its own");
endmodule
bind tlbps_top tlbps_chk chk_u (
   .clk_i           (clk_i),
   .rst_n_i         (rst_n_i),
   .ce_i            (ce_i),
   .wide_mode_bit_i (wide_mode_bit_i),
   .op_valid_i      (op_valid_i),
   .op_ready_o      (op_ready_o),
   .op_done_o       (op_done_o),
   .look_store_i    (look_store_i),
   .look_hit_o      (look_hit_o),
   .reload_valid_i  (reload_valid_i),
   .rc_wr_o         (rc_wr_o),
   .rc_changed_o    (rc_changed_o),
   .bcast_inval_o   (bcast_inval_o),
   .peer_ack_i      (peer_ack_i),
   .op_i            (op_i),
   .op_epn_i        (op_epn_i),
   .look_epn_i      (look_epn_i),
   .reload_epn_i    (reload_epn_i),
   .rc_epn_o        (rc_epn_o),
   .bcast_epn_o     (bcast_epn_o),
   .rc_byte_mask_o  (rc_byte_mask_o),
   .rc_bit_pos_o    (rc_bit_pos_o)
);

/* File: verification/tb.sv */
// self-checking bench for the translation buffer block
`timescale 1ns/1ns
`include "tlbps_map.svh"
module tb;
   import tlbps_pkg::*;
   logic clk_i = 0, rst_n_i = 0, wide = 1, valid = 0, store = 0, rl = 0, mute = 0, ce = 1, acked;
   tlbps_op_t op = TLBPS_OP_NONE;
   logic [19:0] op_epn = '0, look_epn = '0, rl_epn = '0, rl_rpn = '0, real_page_number_field, rc_epn, b_epn;
   logic [6:0] rl_attr = '0, attr;
   logic ready, done, tmo, hit, rc_wr, rc_chg, bcast, ack;
   logic [7:0] mask;
   logic [5:0] pos;
   int n_errors = 0, total_checks = 0;
   always #10 clk_i = ~clk_i;
   tlbps_top #(.SYNC_TIMEOUT_CYC(20)) dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .wide_mode_bit_i(wide),
      .op_i(op), .op_valid_i(valid), .op_epn_i(op_epn), .op_ready_o(ready), .op_done_o(done), .sync_timeout_o(tmo),
      .look_epn_i(look_epn), .look_store_i(store), .look_hit_o(hit), .look_rpn_o(real_page_number_field), .look_attr_o(attr),
      .reload_valid_i(rl), .reload_epn_i(rl_epn), .reload_rpn_i(rl_rpn), .reload_attr_i(rl_attr),
      .rc_wr_o(rc_wr), .rc_changed_o(rc_chg), .rc_epn_o(rc_epn), .rc_byte_mask_o(mask), .rc_bit_pos_o(pos),
      .bcast_inval_o(bcast), .bcast_epn_o(b_epn), .peer_ack_i(ack));
   tlbps_peer peer_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .bcast_i(bcast), .mute_i(mute), .ack_o(ack));
   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: %s", $time, what);
      end
   endtask
   // one edge between calls so valid is never set and cleared in one step
   task automatic issue(input tlbps_op_t code, input logic [19:0] epn);
      int i;
      @(negedge clk_i);
      for (i = 0; i < 50 && ready !== 1'b1; i++) @(negedge clk_i);
      op = code;
      op_epn = epn;
      valid = 1;
      @(negedge clk_i);
      valid = 0;
   endtask
   task automatic wait_done(output logic seen);
      int i;
      seen = 0;
      for (i = 0; i < 200 && done !== 1'b1; i++) begin
         @(negedge clk_i);
         seen |= ack;
      end
      chk(done, 1, "sync never done");
   endtask
   task automatic load(input logic [19:0] epn, input logic [19:0] rp, input logic [6:0] at);
      logic [5:0] exp_pos;
      exp_pos = wide ? 6'(`TLBPS_R_BIT_W64) : 6'(`TLBPS_R_BIT_W32);
      @(negedge clk_i);
      rl = 1;
      rl_epn = epn;
      rl_rpn = rp;
      rl_attr = at;
      @(negedge clk_i);
      rl = 0;
      chk({rc_wr, rc_chg, mask, pos, rc_epn}, {2'b10, ~`TLBPS_R_BYTE_MASK, exp_pos, epn}, "reload update");
   endtask
   task automatic stop_test;
      if (n_errors == 0 && total_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge clk_i);
      n_errors++;
      stop_test;
   end
   initial begin
      repeat (8) @(negedge clk_i);
      rst_n_i = 1;
      @(negedge clk_i);
      chk(ready, 1, "not ready after reset");
      load(20'h00012, 20'hABCDE, 7'h55);
      load(20'h00034, 20'h13579, 7'h2A);
      look_epn = 20'h00012;
      repeat (5) @(negedge clk_i);
      chk({hit, real_page_number_field, attr}, {1'b1, 20'hABCDE, 7'h55}, "lookup lost");
      wide = 0;
      store = 1;
      @(negedge clk_i);
      store = 0;
      chk({rc_wr, rc_chg, pos, rc_epn}, {2'b11, 6'(`TLBPS_R_BIT_W32), 20'h00012}, "store update");
      issue(TLBPS_OP_INVAL, 20'h00012);
      chk({bcast, b_epn, hit}, {1'b1, 20'h00012, 1'b0}, "invalidate");
      @(negedge clk_i);
      look_epn = 20'h00034;
      #1;
      chk({hit, real_page_number_field}, {1'b1, 20'h13579}, "other page dropped");
      issue(TLBPS_OP_SYNC, '0);
      wait_done(acked);
      chk(acked, 1, "sync ahead of peers");
      issue(TLBPS_OP_FULL, '0);
      wait_done(acked);
      // page moved to a new address, old one invalidated with the sync on the very next edge
      load(20'h00056, 20'h2468A, 7'h11);
      load(20'h00078, 20'h2468A, 7'h11);
      @(negedge clk_i);
      op = TLBPS_OP_INVAL;
      op_epn = 20'h00056;
      valid = 1;
      @(negedge clk_i);
      op = TLBPS_OP_SYNC;
      @(negedge clk_i);
      valid = 0;
      wait_done(acked);
      chk(acked, 1, "sync before invalidate answered");
      @(negedge clk_i);
      look_epn = 20'h00056;
      #1;
      chk(hit, 0, "old page still mapped");
      @(negedge clk_i);
      look_epn = 20'h00078;
      #1;
      chk({hit, real_page_number_field}, {1'b1, 20'h2468A}, "moved page lost");
      issue(TLBPS_OP_INVAL, 20'h00034);
      mute = 1;
      issue(TLBPS_OP_SYNC, '0);
      repeat (30) @(negedge clk_i);
      chk({tmo, done}, 2'b10, "peer wait");
      mute = 0;
      wait_done(acked);
      // frozen clock enable: a store hit posts nothing and no op is taken
      @(negedge clk_i);
      ce = 0;
      store = 1;
      @(negedge clk_i);
      chk({rc_wr, ready}, 2'b00, "update while frozen");
      ce = 1;
      store = 0;
      @(negedge clk_i);
      stop_test;
   end
endmodule
